// *** include/sbt_pkg.sv ***
// Constants shared by the sink blink timer and its register slave.
// What this block does
// - Enabled blinking sink stays lit for the shared on time, then goes dark.
// - Shared on-time field bits 7:6 select 0.2, 0.6, 0.8 or 1.2 s.
// - Sink 7 dark-time field bits 5:4: disabled, 0.6, 1.2 or 1.8 s.
// - Sink 6 dark-time field bits 3:2: disabled, 0.6, 1.2 or 1.8 s.
// - Sink 5 dark-time field bits 1:0: disabled, 0.6, 1.2 or 1.8 s.
// - Nonzero dark code: dark for that time, lit again, repeating while enabled.
// - Enabled sink with dark code 00 stays lit without blinking.
// - Sinks enabled by one write start their sequences in the same cycle.
// - Enable register holds sink 7 at bit 6 down to sink 1 at bit 0.
package sbt_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] SBT_ENABLE_IDX = 8'h10;
	localparam logic [7:0] SBT_TIMING_IDX = 8'h11;
	localparam logic [7:0] SBT_STATUS_IDX = 8'h20;

	// Reset values of the writable registers.
	localparam logic [6:0] SBT_ENABLE_RST = 7'h00;
	localparam logic [7:0] SBT_TIMING_RST = 8'h00;

	// Field layout of the timing register.
	localparam int SBT_FIELD_W = 2;
	localparam int SBT_ON_LSB = 6;
	localparam int SBT_DARK7_LSB = 4;
	localparam int SBT_DARK6_LSB = 2;
	localparam int SBT_DARK5_LSB = 0;

	// Sink count and the position of sink 5 in the enable register.
	localparam int SBT_NUM_SINKS = 7;
	localparam int SBT_NUM_BLINK = 3;
	localparam int SBT_SINK5_BIT = 4;

	// AXI response codes.
	localparam logic [1:0] SBT_RESP_OKAY = 2'h0;
	localparam logic [1:0] SBT_RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Timing: every duration is a whole number of 0.2 s units.
	localparam int unsigned SBT_CLK_PERIOD_NS = 10;
	localparam int unsigned SBT_UNIT_MS = 200;
	localparam int unsigned SBT_UNIT_CYCLES =
		SBT_UNIT_MS * 1000000 / SBT_CLK_PERIOD_NS;
	localparam int unsigned SBT_ON_MS_0 = 200;
	localparam int unsigned SBT_ON_MS_1 = 600;
	localparam int unsigned SBT_ON_MS_2 = 800;
	localparam int unsigned SBT_ON_MS_3 = 1200;
	localparam int unsigned SBT_DARK_MS_1 = 600;
	localparam int unsigned SBT_DARK_MS_2 = 1200;
	localparam int unsigned SBT_DARK_MS_3 = 1800;

	// Lit time of an on-time code, in units.
	function automatic logic [3:0] sbt_on_units(input logic [1:0] code);
		logic [3:0] u;
		u = 4'h0;
		unique case (code)
			2'h0: u = 4'(SBT_ON_MS_0 / SBT_UNIT_MS);
			2'h1: u = 4'(SBT_ON_MS_1 / SBT_UNIT_MS);
			2'h2: u = 4'(SBT_ON_MS_2 / SBT_UNIT_MS);
			2'h3: u = 4'(SBT_ON_MS_3 / SBT_UNIT_MS);
		endcase
		return u;
	endfunction

	// Dark time of a dark-time code, in units; code 0 means no dark phase.
	function automatic logic [3:0] sbt_dark_units(input logic [1:0] code);
		logic [3:0] u;
		u = 4'h0;
		unique case (code)
			2'h0: u = 4'h0;
			2'h1: u = 4'(SBT_DARK_MS_1 / SBT_UNIT_MS);
			2'h2: u = 4'(SBT_DARK_MS_2 / SBT_UNIT_MS);
			2'h3: u = 4'(SBT_DARK_MS_3 / SBT_UNIT_MS);
		endcase
		return u;
	endfunction

endpackage

// *** include/sbt_sink_if.sv ***
// Link between the register block and one blinking sink timer.
`timescale 1ns/1ps
interface sbt_sink_if;
	logic enable;
	logic hold_lit;
	logic [31:0] on_cycles;
	logic [31:0] dark_cycles;
	logic lit;

	// Register side drives the settings and watches the sink.
	modport ctrl (output enable, hold_lit, on_cycles, dark_cycles,
		input lit);

	// Timer side follows the settings and drives the sink.
	modport timer (input enable, hold_lit, on_cycles, dark_cycles,
		output lit);
endinterface

// *** hdl/sbt_sink_timer.sv ***
// On/dark sequencer for one blinking current sink.
`timescale 1ns/1ps
module sbt_sink_timer
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic srst,
	// Settings in, sink state out.
	sbt_sink_if.timer link
);
	import sbt_pkg::*;

	typedef enum logic [1:0] {SBT_IDLE, SBT_LIT, SBT_DARK} sbt_phase_t;

	typedef struct packed
	{
		sbt_phase_t phase;
		logic [31:0] count;
		logic lit;
	} sbt_timer_state_t;

	sbt_timer_state_t state_q;
	sbt_timer_state_t state_d;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic. Comparisons use >= so that a shorter time written
	// in mid-phase ends the phase at once rather than waiting for a wrap.
	always_comb
	begin
		state_d = state_q;
		unique case (state_q.phase)
			SBT_IDLE:
			begin
				if (link.enable)
				begin
					state_d.phase = SBT_LIT;
					state_d.count = 32'h0;
					state_d.lit = 1'b1;
				end
			end
			SBT_LIT:
			begin
				if (link.hold_lit)
					state_d.count = 32'h0;
				else if (state_q.count >= link.on_cycles - 32'h1)
				begin
					state_d.phase = SBT_DARK;
					state_d.count = 32'h0;
					state_d.lit = 1'b0;
				end
				else
					state_d.count = state_q.count + 32'h1;
			end
			SBT_DARK:
			begin
				if (link.hold_lit ||
					state_q.count >= link.dark_cycles - 32'h1)
				begin
					state_d.phase = SBT_LIT;
					state_d.count = 32'h0;
					state_d.lit = 1'b1;
				end
				else
					state_d.count = state_q.count + 32'h1;
			end
			// The fourth phase code is unused; fall back to a dark idle.
			default:
			begin
				state_d.phase = SBT_IDLE;
				state_d.count = 32'h0;
				state_d.lit = 1'b0;
			end
		endcase
		if (!link.enable)
		begin
			state_d.phase = SBT_IDLE;
			state_d.count = 32'h0;
			state_d.lit = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state_q.phase <= SBT_IDLE;
			state_q.count <= 32'h0;
			state_q.lit <= 1'b0;
		end
		else
			state_q <= state_d;
	end

	assign link.lit = state_q.lit;
endmodule

// *** hdl/sbt_top.sv ***
// Register slave and sink outputs of the blink timer for sinks 1 to 7.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module sbt_top
#(
	parameter int ADDR_W = 8,
	parameter int unsigned UNIT_CYCLES = sbt_pkg::SBT_UNIT_CYCLES
)
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic srst,
	// AXI4-Lite write address channel.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data channel.
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address channel.
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Current sink drive, bit 0 is sink 1.
	output logic [sbt_pkg::SBT_NUM_SINKS-1:0] sink_lit
);
	import sbt_pkg::*;

	localparam logic [ADDR_W-1:0] ENABLE_ADDR =
		ADDR_W'({SBT_ENABLE_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] TIMING_ADDR =
		ADDR_W'({SBT_TIMING_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] STATUS_ADDR =
		ADDR_W'({SBT_STATUS_IDX, 2'b00});
	localparam int STEADY = SBT_SINK5_BIT;

	typedef struct packed
	{
		logic aw_have;
		logic [ADDR_W-1:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [SBT_NUM_SINKS-1:0] enable;
		logic [7:0] timing;
		logic [STEADY-1:0] steady_lit;
	} sbt_top_state_t;

	sbt_top_state_t state_q;
	sbt_top_state_t state_d;
	logic [SBT_NUM_BLINK-1:0] blink_lit;

	sbt_sink_if sink_link[SBT_NUM_BLINK] ();

	////////////////////////////////////////////////////////////////////////
	// Read multiplexer; unmapped addresses answer zero with an error.
	function automatic logic [32:0] read_word(
		input logic [ADDR_W-1:0] addr,
		input sbt_top_state_t s,
		input logic [SBT_NUM_SINKS-1:0] lit);
		logic [32:0] r;
		r = {1'b1, 32'h0};
		if (addr == ENABLE_ADDR)
			r = {1'b0, 25'h0, s.enable};
		else if (addr == TIMING_ADDR)
			r = {1'b0, 24'h0, s.timing};
		else if (addr == STATUS_ADDR)
			r = {1'b0, 25'h0, lit};
		return r;
	endfunction

	// Channel readies: one write and one read in flight at most.
	assign s_axi_awready = !state_q.aw_have && !state_q.bvalid;
	assign s_axi_wready = !state_q.w_have && !state_q.bvalid;
	assign s_axi_arready = !state_q.rvalid;

	////////////////////////////////////////////////////////////////////////
	// Bus slave and register update.
	always_comb
	begin
		logic [32:0] rd;
		rd = read_word(s_axi_araddr, state_q, sink_lit);
		state_d = state_q;
		// Address and data are caught independently, in either order.
		if (s_axi_awvalid && s_axi_awready)
		begin
			state_d.aw_have = 1'b1;
			state_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			state_d.w_have = 1'b1;
			state_d.wdata = s_axi_wdata;
			state_d.wstrb0 = s_axi_wstrb[0];
		end
		if (state_q.bvalid && s_axi_bready)
			state_d.bvalid = 1'b0;
		// Commit once both halves are held. All enables of one word land
		// in the same cycle, so the timers they start stay in step.
		if (state_q.aw_have && state_q.w_have && !state_q.bvalid)
		begin
			state_d.aw_have = 1'b0;
			state_d.w_have = 1'b0;
			state_d.bvalid = 1'b1;
			state_d.bresp = SBT_RESP_OKAY;
			if (state_q.awaddr == ENABLE_ADDR)
			begin
				if (state_q.wstrb0)
					state_d.enable = state_q.wdata[SBT_NUM_SINKS-1:0];
			end
			else if (state_q.awaddr == TIMING_ADDR)
			begin
				if (state_q.wstrb0)
					state_d.timing = state_q.wdata[7:0];
			end
			// Status is read only; a write to it is dropped quietly.
			else if (state_q.awaddr != STATUS_ADDR)
				state_d.bresp = SBT_RESP_SLVERR;
		end
		// Reads answer one cycle after the address is taken.
		if (state_q.rvalid && s_axi_rready)
			state_d.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			state_d.rvalid = 1'b1;
			state_d.rdata = rd[31:0];
			state_d.rresp = rd[32] ? SBT_RESP_SLVERR : SBT_RESP_OKAY;
		end
		state_d.steady_lit = state_q.enable[STEADY-1:0];
	end

	// State register.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state_q <= '0;
			state_q.enable <= SBT_ENABLE_RST;
			state_q.timing <= SBT_TIMING_RST;
		end
		else
			state_q <= state_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Blink timers for sinks 5, 6 and 7. Times are products of the unit
	// count; the largest, 1.8 s, still fits 32 bits at the default rate.
	for (genvar i = 0; i < SBT_NUM_BLINK; i++)
	begin : g_blink
		logic [1:0] dark_code;
		assign dark_code =
			state_q.timing[SBT_DARK5_LSB + SBT_FIELD_W*i +: SBT_FIELD_W];
		assign sink_link[i].enable = state_q.enable[SBT_SINK5_BIT + i];
		assign sink_link[i].hold_lit = (dark_code == 2'h0);
		assign sink_link[i].on_cycles = 32'(UNIT_CYCLES *
			32'(sbt_on_units(state_q.timing[SBT_ON_LSB +: SBT_FIELD_W])));
		assign sink_link[i].dark_cycles = 32'(UNIT_CYCLES *
			32'(sbt_dark_units(dark_code)));
		assign blink_lit[i] = sink_link[i].lit;

		sbt_sink_timer u_timer
		(
			.clk_sys(clk_sys),
			.srst(srst),
			.link(sink_link[i])
		);
	end

	// Outputs.
	assign sink_lit = {blink_lit, state_q.steady_lit};
	assign s_axi_bvalid = state_q.bvalid;
	assign s_axi_bresp = state_q.bresp;
	assign s_axi_rvalid = state_q.rvalid;
	assign s_axi_rdata = state_q.rdata;
	assign s_axi_rresp = state_q.rresp;
endmodule

// *** verification/sbt_led_model.sv ***
// LED model: measures the last finished lit and dark run of each sink.
`timescale 1ns/1ps
module sbt_led_model
(
	// Clock.
	input wire logic clk_sys,
	// Sink drive from the block.
	input wire logic [6:0] sink_lit
);
	int cnt[7];
	int lit_len[7];
	int dark_len[7];
	logic [6:0] prev = 7'h00;
	// Sampled mid-cycle, so the flop update at the edge never races.
	always @(negedge clk_sys)
	begin
		for (int i = 0; i < 7; i++)
		begin
			if (sink_lit[i] !== prev[i])
			begin
				if (prev[i])
					lit_len[i] = cnt[i];
				else
					dark_len[i] = cnt[i];
				cnt[i] = 1;
			end
			else
				cnt[i]++;
		end
		prev = sink_lit;
	end
endmodule

// *** verification/sbt_top_asserts.sv ***
// Bus and sink output checks for the blink timer top.
`timescale 1ns/1ps
module sbt_top_asserts
(
	// Clock, reset and bus handshakes.
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Sink drive.
	input wire logic [sbt_pkg::SBT_NUM_SINKS-1:0] sink_lit
);
	import sbt_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////
	// Answers stand until taken; refused requests keep ready low.
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	a_write_refuse: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("write not held");
	a_read_refuse: assert property (s_axi_rvalid
		|-> !s_axi_arready) else $error("read not held");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_upper_zero: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
	a_unmapped_zero: assert property (s_axi_rvalid
		&& s_axi_rresp == SBT_RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read data");
	// Reset darkens every sink even while reset is still high.
	a_reset_dark: assert property (disable iff (1'b0) srst
		|=> sink_lit == 7'h00) else $error("sink lit after reset");
	c_all_blink: cover property (sink_lit[6:4] == 3'h7);
	c_dark_start: cover property ($fell(sink_lit[4]));
	c_error_resp: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind sbt_top sbt_top_asserts i_sbt_top_asserts (.clk_sys(clk_sys),
	.srst(srst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.sink_lit(sink_lit));

// *** verification/sbt_top_tb.sv ***
// Register and blink sequence bench for the blink timer.
`timescale 1ns/1ps
module sbt_top_tb;
	import sbt_pkg::*;
	localparam int U = 2;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [6:0] sink_lit;
	int errors = 0;
	int samples_checked = 0;
	int on_u[4] = '{1, 3, 4, 6};
	sbt_top #(.UNIT_CYCLES(U)) i_sbt_top (.clk_sys(clk_sys), .srst(srst),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sink_lit(sink_lit));
	sbt_led_model i_sbt_led_model (.clk_sys(clk_sys), .sink_lit(sink_lit));
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////
	// Handshakes are read mid-cycle, which equals what the edge samples.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic pa, pw, ta, tw, b;
		logic [1:0] r;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw)
		begin
			@(negedge clk_sys);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge clk_sys);
			if (ta)
			begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw)
			begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do
		begin
			@(negedge clk_sys);
			b = bvalid;
			r = bresp;
			@(posedge clk_sys);
		end while (!b);
		bready <= 1'b0;
		// Let an edge pass so a following call never re-raises bready
		// in the time step that lowered it.
		@(posedge clk_sys);
		chk(32'(r), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic t;
		logic [31:0] d;
		logic [1:0] r;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(negedge clk_sys);
			t = arready;
			@(posedge clk_sys);
		end while (!t);
		arvalid <= 1'b0;
		do
		begin
			@(negedge clk_sys);
			t = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
		end while (!t);
		rready <= 1'b0;
		// Same spacing as the write task, for rready.
		@(posedge clk_sys);
		chk(d, ed);
		chk(32'(r), 32'(er));
	endtask
	task automatic final_report();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Register map, steady drive, then each on code against fixed dark codes.
	initial
	begin
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		rd(8'h40, 32'h0, SBT_RESP_OKAY);
		rd(8'h44, 32'h0, SBT_RESP_OKAY);
		rd(8'h4c, 32'h0, SBT_RESP_SLVERR);
		wr(8'h4c, 32'h1, 4'hf, SBT_RESP_SLVERR);
		wr(8'h44, 32'h5a, 4'h0, SBT_RESP_OKAY);
		rd(8'h44, 32'h0, SBT_RESP_OKAY);
		wr(8'h40, 32'h7f, 4'hf, SBT_RESP_OKAY);
		repeat (40) @(negedge clk_sys) chk(32'(sink_lit), 32'h7f);
		rd(8'h80, 32'h7f, SBT_RESP_OKAY);
		// Clear every enable first so each pass starts its timers afresh.
		wr(8'h40, 32'h0, 4'hf, SBT_RESP_OKAY);
		@(negedge clk_sys) chk(32'(sink_lit), 32'h0);
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h44, 32'({c[1:0], 6'h39}), 4'hf, SBT_RESP_OKAY);
			wr(8'h40, 32'h70, 4'hf, SBT_RESP_OKAY);
			@(negedge clk_sys) chk(32'(sink_lit), 32'h70);
			repeat (80) @(negedge clk_sys);
			for (int i = 4; i < 7; i++)
				chk(i_sbt_led_model.lit_len[i], on_u[c] * U);
			chk(i_sbt_led_model.dark_len[4], 3 * U);
			chk(i_sbt_led_model.dark_len[5], 6 * U);
			chk(i_sbt_led_model.dark_len[6], 9 * U);
			wr(8'h40, 32'h0, 4'hf, SBT_RESP_OKAY);
			@(negedge clk_sys) chk(32'(sink_lit), 32'h0);
		end
		// Equal settings from one enable write must blink as one.
		wr(8'h44, 32'h15, 4'hf, SBT_RESP_OKAY);
		wr(8'h40, 32'h70, 4'hf, SBT_RESP_OKAY);
		repeat (40) @(negedge clk_sys)
			chk(32'(sink_lit[6:4] == 3'h0 || sink_lit[6:4] == 3'h7), 1);
		wr(8'h44, 32'h0, 4'hf, SBT_RESP_OKAY);
		@(negedge clk_sys) chk(32'(sink_lit), 32'h70);
		final_report();
	end
	// Watchdog well beyond the few hundred cycles the sequence needs.
	initial
	begin
		#50us;
		errors++;
		final_report();
	end
endmodule
